// file: hw/rcaws_map.vh
// register offsets, field positions and timing constants for the rtc support block
`ifndef RCAWS_MAP_VH
`define RCAWS_MAP_VH
`define RCAWS_ADDR_CTRL 8'h08
`define RCAWS_ADDR_WDOG 8'h09
`define RCAWS_ADDR_ALMON 8'h0a
`define RCAWS_ADDR_ALDATE 8'h0b
`define RCAWS_ADDR_ALHOUR 8'h0c
`define RCAWS_ADDR_ALMIN 8'h0d
`define RCAWS_ADDR_ALSEC 8'h0e
`define RCAWS_ADDR_FLAGS 8'h0f
`define RCAWS_ADDR_SQW 8'h13
`define RCAWS_CTRL_OUT 7
`define RCAWS_CTRL_FT 6
`define RCAWS_CTRL_SIGN 5
`define RCAWS_WD_STEER 7
`define RCAWS_AL_AFE 7
`define RCAWS_AL_SQUARE_OUT_ENABLE 6
`define RCAWS_AL_ABE 5
`define RCAWS_FL_WDF 7
`define RCAWS_FL_AF 6
`define RCAWS_FL_BL 4
`define RCAWS_CTRL_RST 8'h80
`define RCAWS_ZERO8 8'h00
`define RCAWS_REP_SEC 5'h1f
`define RCAWS_REP_MIN 5'h1e
`define RCAWS_REP_HOUR 5'h1c
`define RCAWS_REP_DAY 5'h18
`define RCAWS_REP_MON 5'h10
`define RCAWS_REP_YEAR 5'h00
`define RCAWS_OSC_HZ 32768
`define RCAWS_DIV_TOP 15'h7fff
`define RCAWS_SEC_CYC 16'h8000
`define RCAWS_NEG_ADJ 16'h0080
`define RCAWS_POS_ADJ 16'h0100
`define RCAWS_CAL_MINS 6'h3f
`define RCAWS_CAL_LAST 6'h3e
`define RCAWS_MIN_SECS 6'h3b
`define RCAWS_FT_BIT 5
`define RCAWS_TREC_LONG_MS 97
`define RCAWS_TREC_DEF_MS 120
`define RCAWS_TREC_SHORT_US 1000
`define RCAWS_TICKS_16TH 16'h0800
`endif

// file: hw/rcaws_top.v
// rtc calibration, frequency test, alarm, watchdog and square-wave support block
// Functional notes
// - calibration adds or removes counts at the divide-by-256 divider stage
// - calibration magnitude is bits 4..0; bit 5 set means speed up
// - 64-minute cycle; affected minute changes one second by +128 or -256 cycles
// - magnitude n modifies only the first 2n minutes of each cycle
// - shared pin toggles at 512 hz under the frequency test conditions
// - five repeat bits choose second, minute, hour, day, month or year match
// - undefined repeat patterns behave as once per second
// - match sets alarm_flag and asserts the shared pin if enabled
// - pointer resting on flags register holds off alarm flag and interrupt
// - flags read releases alarm interrupt; second read shows flag cleared
// - in backup, alarm drives pin only with both backup and irq enables
// - power-up clears backup and irq enables; alarm then only sets flag
// - timeout is multiplier times resolution of 1/16, 1/4, 1 or 4 s
// - missed restart sets watchdog_flag and raises interrupt or reset
// - steering 0 asserts shared pin; steering 1 pulses reset for recovery time
// - reset-steered timeout clears watchdog register and enable bits
// - either kick_input edge or watchdog register write restarts count
// - host writes zero to watchdog register to release pin and disable it
// - flags read clears watchdog_flag in bit 7 of register 0fh
// - interrupt-steered watchdog owns the pin and suppresses frequency test
// - rate code 0 is off, 1 is 16.384 khz, each code halves to 1 hz
// - square output only while square_out_enable set; rate kept when cleared
// - with test, alarm irq and watchdog all clear, pin follows out_level
// - recovery time depends on recovery_select and oscillator_halt
`include "rcaws_map.vh"
`timescale 1ns/100ps
`default_nettype none
module rcaws_top #(
    parameter integer CLK_HZ = 100000000,
    parameter integer TREC_LONG_CYC = 9700000,
    parameter integer TREC_DEF_CYC = 12000000,
    parameter integer TREC_SHORT_CYC = 100000
) (
    input wire mclk,
    input wire rst,
    input wire osc_tick,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] ptr_addr,
    input wire oscillator_halt,
    input wire recovery_select,
    input wire battery_backup,
    input wire battery_low_flag,
    input wire kick_input,
    input wire [4:0] time_month,
    input wire [5:0] time_date,
    input wire [5:0] time_hour,
    input wire [6:0] time_min,
    input wire [6:0] time_sec,
    output reg [7:0] reg_rdata,
    output reg second_tick,
    output reg shared_interrupt_pin_o,
    output reg shared_interrupt_pin_oe_n,
    output reg reset_out_n,
    output reg square_out
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] wdog_q;
    reg [7:0] al_mon_q;
    reg [7:0] al_date_q;
    reg [7:0] al_hour_q;
    reg [7:0] al_min_q;
    reg [7:0] al_sec_q;
    reg [3:0] square_rate_bits_q;
    reg alarm_flag_q;
    reg watchdog_flag_q;
    reg alarm_irq_q;
    reg wd_irq_q;
    reg alarm_pend_q;
    wire freq_test_enable = ctrl_q[`RCAWS_CTRL_FT];
    wire out_level = ctrl_q[`RCAWS_CTRL_OUT];
    wire alarm_irq_enable = al_mon_q[`RCAWS_AL_AFE];
    wire square_out_enable = al_mon_q[`RCAWS_AL_SQUARE_OUT_ENABLE];
    wire alarm_in_backup_enable = al_mon_q[`RCAWS_AL_ABE];
    wire watchdog_to_reset = wdog_q[`RCAWS_WD_STEER];
    wire [4:0] timeout_multiplier = wdog_q[6:2];
    wire [1:0] timeout_resolution = wdog_q[1:0];
    wire [4:0] cal_mag = ctrl_q[4:0];
    wire cal_pos = ctrl_q[`RCAWS_CTRL_SIGN];
    wire [4:0] alarm_repeat_bits = {al_date_q[6], al_date_q[7], al_hour_q[7], al_min_q[7], al_sec_q[7]};
    wire flags_rd = reg_rd && (reg_addr == `RCAWS_ADDR_FLAGS);
    wire wdog_wr = reg_wr && (reg_addr == `RCAWS_ADDR_WDOG);

    // ----------------------------------------
    // calibrated divider chain
    // ----------------------------------------
    reg [15:0] div_q;
    reg [5:0] sec_in_min_q;
    reg [5:0] min_in_cyc_q;
    reg adj_done_q;
    reg [15:0] sec_len;
    wire cal_minute = (min_in_cyc_q < {cal_mag, 1'b0}) && (min_in_cyc_q < `RCAWS_CAL_LAST);
    always @*
    begin
        sec_len = `RCAWS_SEC_CYC;
        if (cal_minute && !adj_done_q && (cal_mag != 5'h00))
        begin
            if (cal_pos)
                sec_len = `RCAWS_SEC_CYC - `RCAWS_POS_ADJ;
            else
                sec_len = `RCAWS_SEC_CYC + `RCAWS_NEG_ADJ;
        end
    end
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            div_q <= 16'h0000;
            sec_in_min_q <= 6'h00;
            min_in_cyc_q <= 6'h00;
            adj_done_q <= 1'b0;
            second_tick <= 1'b0;
        end
        else
        begin
            second_tick <= 1'b0;
            if (osc_tick && !oscillator_halt)
            begin
                if (div_q >= sec_len - 16'h0001)
                begin
                    div_q <= 16'h0000;
                    second_tick <= 1'b1;
                    if (cal_minute && (cal_mag != 5'h00))
                        adj_done_q <= 1'b1;
                    if (sec_in_min_q == `RCAWS_MIN_SECS)
                    begin
                        sec_in_min_q <= 6'h00;
                        adj_done_q <= 1'b0;
                        min_in_cyc_q <= (min_in_cyc_q == `RCAWS_CAL_MINS) ? 6'h00 : min_in_cyc_q + 6'h01;
                    end
                    else
                        sec_in_min_q <= sec_in_min_q + 6'h01;
                end
                else
                    div_q <= div_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // uncalibrated prescaler for test and square wave
    // ----------------------------------------
    reg [14:0] pre_q;
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            pre_q <= 15'h0000;
        else if (osc_tick && !oscillator_halt)
            pre_q <= pre_q + 15'h0001;
    end

    // ----------------------------------------
    // alarm match
    // ----------------------------------------
    reg alarm_match;
    always @*
    begin
        alarm_match = 1'b0;
        case (alarm_repeat_bits)
            `RCAWS_REP_MIN: alarm_match = (time_sec == al_sec_q[6:0]);
            `RCAWS_REP_HOUR: alarm_match = (time_sec == al_sec_q[6:0]) && (time_min == al_min_q[6:0]);
            `RCAWS_REP_DAY: alarm_match = (time_sec == al_sec_q[6:0]) && (time_min == al_min_q[6:0])
                && (time_hour == al_hour_q[5:0]);
            `RCAWS_REP_MON: alarm_match = (time_sec == al_sec_q[6:0]) && (time_min == al_min_q[6:0])
                && (time_hour == al_hour_q[5:0]) && (time_date == al_date_q[5:0]);
            `RCAWS_REP_YEAR: alarm_match = (time_sec == al_sec_q[6:0]) && (time_min == al_min_q[6:0])
                && (time_hour == al_hour_q[5:0]) && (time_date == al_date_q[5:0])
                && (time_month == al_mon_q[4:0]);
            default: alarm_match = 1'b1;
        endcase
    end

    // ----------------------------------------
    // watchdog timer
    // ----------------------------------------
    reg [15:0] tick16_q;
    reg [11:0] wd_cnt_q;
    reg kick_q;
    reg [23:0] trec_q;
    reg [11:0] wd_limit;
    reg [23:0] trec_len;
    wire wd_tick = osc_tick && (tick16_q == `RCAWS_TICKS_16TH - 16'h0001);
    always @*
    begin
        case (timeout_resolution)
            2'b00: wd_limit = {7'h00, timeout_multiplier};
            2'b01: wd_limit = {5'h00, timeout_multiplier, 2'b00};
            2'b10: wd_limit = {3'h0, timeout_multiplier, 4'h0};
            default: wd_limit = {1'b0, timeout_multiplier, 6'h00};
        endcase
        if (recovery_select)
            trec_len = TREC_SHORT_CYC[23:0];
        else if (oscillator_halt)
            trec_len = TREC_DEF_CYC[23:0];
        else
            trec_len = TREC_LONG_CYC[23:0];
    end
    wire wd_armed = (timeout_multiplier != 5'h00);
    wire wd_fire = wd_armed && wd_tick && (wd_cnt_q + 12'h001 >= wd_limit) && !wd_irq_q;

    // ----------------------------------------
    // registers, flags and events
    // ----------------------------------------
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= `RCAWS_CTRL_RST;
            wdog_q <= `RCAWS_ZERO8;
            al_mon_q <= `RCAWS_ZERO8;
            al_date_q <= `RCAWS_ZERO8;
            al_hour_q <= `RCAWS_ZERO8;
            al_min_q <= `RCAWS_ZERO8;
            al_sec_q <= `RCAWS_ZERO8;
            square_rate_bits_q <= 4'h0;
            alarm_flag_q <= 1'b0;
            watchdog_flag_q <= 1'b0;
            alarm_irq_q <= 1'b0;
            wd_irq_q <= 1'b0;
            alarm_pend_q <= 1'b0;
            tick16_q <= 16'h0000;
            wd_cnt_q <= 12'h000;
            kick_q <= 1'b0;
            trec_q <= 24'h000000;
            reset_out_n <= 1'b1;
            reg_rdata <= `RCAWS_ZERO8;
        end
        else
        begin
            kick_q <= kick_input;
            if (osc_tick)
                tick16_q <= wd_tick ? 16'h0000 : tick16_q + 16'h0001;
            if (reg_wr)
            begin
                if (reg_addr == `RCAWS_ADDR_CTRL)
                    ctrl_q <= reg_wdata;
                else if (reg_addr == `RCAWS_ADDR_WDOG)
                    wdog_q <= reg_wdata;
                else if (reg_addr == `RCAWS_ADDR_ALMON)
                    al_mon_q <= reg_wdata;
                else if (reg_addr == `RCAWS_ADDR_ALDATE)
                    al_date_q <= reg_wdata;
                else if (reg_addr == `RCAWS_ADDR_ALHOUR)
                    al_hour_q <= reg_wdata;
                else if (reg_addr == `RCAWS_ADDR_ALMIN)
                    al_min_q <= reg_wdata;
                else if (reg_addr == `RCAWS_ADDR_ALSEC)
                    al_sec_q <= reg_wdata;
                else if (reg_addr == `RCAWS_ADDR_SQW)
                    square_rate_bits_q <= reg_wdata[7:4];
            end
            if (reg_rd)
            begin
                if (reg_addr == `RCAWS_ADDR_CTRL)
                    reg_rdata <= ctrl_q;
                else if (reg_addr == `RCAWS_ADDR_WDOG)
                    reg_rdata <= wdog_q;
                else if (reg_addr == `RCAWS_ADDR_ALMON)
                    reg_rdata <= al_mon_q;
                else if (reg_addr == `RCAWS_ADDR_ALDATE)
                    reg_rdata <= al_date_q;
                else if (reg_addr == `RCAWS_ADDR_ALHOUR)
                    reg_rdata <= al_hour_q;
                else if (reg_addr == `RCAWS_ADDR_ALMIN)
                    reg_rdata <= al_min_q;
                else if (reg_addr == `RCAWS_ADDR_ALSEC)
                    reg_rdata <= al_sec_q;
                else if (reg_addr == `RCAWS_ADDR_FLAGS)
                    reg_rdata <= {watchdog_flag_q, alarm_flag_q, 1'b0, battery_low_flag, 4'h0};
                else if (reg_addr == `RCAWS_ADDR_SQW)
                    reg_rdata <= {square_rate_bits_q, 4'h0};
                else
                    reg_rdata <= `RCAWS_ZERO8;
            end
            if (flags_rd)
            begin
                alarm_flag_q <= 1'b0;
                alarm_irq_q <= 1'b0;
                watchdog_flag_q <= 1'b0;
            end
            if ((second_tick && alarm_match) || alarm_pend_q)
            begin
                if (ptr_addr == `RCAWS_ADDR_FLAGS)
                    alarm_pend_q <= 1'b1;
                else
                begin
                    alarm_pend_q <= 1'b0;
                    alarm_flag_q <= 1'b1;
                    if (alarm_irq_enable && (!battery_backup || alarm_in_backup_enable))
                        alarm_irq_q <= 1'b1;
                end
            end
            if (wdog_wr || (kick_q != kick_input) || !wd_armed)
                wd_cnt_q <= 12'h000;
            else if (wd_tick && !wd_irq_q)
                wd_cnt_q <= wd_cnt_q + 12'h001;
            if (wdog_wr && (reg_wdata == `RCAWS_ZERO8))
                wd_irq_q <= 1'b0;
            if (wd_fire)
            begin
                watchdog_flag_q <= 1'b1;
                wd_cnt_q <= 12'h000;
                if (watchdog_to_reset)
                begin
                    reset_out_n <= 1'b0;
                    trec_q <= trec_len;
                end
                else
                    wd_irq_q <= 1'b1;
            end
            else if (!reset_out_n)
            begin
                if (trec_q <= 24'h000001)
                begin
                    reset_out_n <= 1'b1;
                    wdog_q <= `RCAWS_ZERO8;
                    ctrl_q[`RCAWS_CTRL_FT] <= 1'b0;
                    al_mon_q[`RCAWS_AL_AFE] <= 1'b0;
                    al_mon_q[`RCAWS_AL_ABE] <= 1'b0;
                    al_mon_q[`RCAWS_AL_SQUARE_OUT_ENABLE] <= 1'b0;
                end
                else
                    trec_q <= trec_q - 24'h000001;
            end
        end
    end

    // ----------------------------------------
    // shared pin and square wave
    // ----------------------------------------
    reg pin_low;
    wire wd_zero = (wdog_q == `RCAWS_ZERO8);
    wire ft_on = !oscillator_halt && freq_test_enable && !alarm_irq_enable && (watchdog_to_reset || wd_zero);
    wire sqw_sel = (square_rate_bits_q == 4'h1) ? pre_q[0] : pre_q[square_rate_bits_q - 4'h1];
    always @*
    begin
        pin_low = alarm_irq_q || wd_irq_q || (ft_on && !pre_q[`RCAWS_FT_BIT])
            || (!freq_test_enable && !alarm_irq_enable && wd_zero && !out_level);
    end
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            shared_interrupt_pin_o <= 1'b0;
            shared_interrupt_pin_oe_n <= 1'b1;
            square_out <= 1'b0;
        end
        else
        begin
            shared_interrupt_pin_o <= 1'b0;
            shared_interrupt_pin_oe_n <= !pin_low;
            square_out <= square_out_enable && (square_rate_bits_q != 4'h0) && sqw_sel;
        end
    end
endmodule
`default_nettype wire

// file: test/rcaws_chk_asserts.sv
// concurrent checks on the ports of the rtc support block
`timescale 1ns/100ps
`default_nettype none
module rcaws_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic kick_input,
    input wire logic [7:0] reg_rdata,
    input wire logic second_tick,
    input wire logic shared_interrupt_pin_o,
    input wire logic reset_out_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_pin_open_drain: assert property (shared_interrupt_pin_o == 1'b0)
        else $error("shared pin data not low");
    chk_rate_bits_kept: assert property (reg_wr && reg_addr == 8'h13 ##2 reg_rd && reg_addr == 8'h13
        |=> reg_rdata[7:4] == $past(reg_wdata[7:4], 3)) else $error("rate bits not kept");
    chk_wdf_read_clear: assert property (reg_rd && reg_addr == 8'h0f ##2 reg_rd && reg_addr == 8'h0f
        |=> !reg_rdata[7]) else $error("watchdog flag not cleared by read");
    chk_af_read_clear: assert property (reg_rd && reg_addr == 8'h0f ##2 reg_rd && reg_addr == 8'h0f
        |=> !reg_rdata[6]) else $error("alarm flag not cleared by read");
    chk_wdog_write_kick: assert property (reg_wr && reg_addr == 8'h09 && reset_out_n |=> reset_out_n [*8])
        else $error("reset soon after watchdog write");
    chk_kick_edge_kick: assert property ($changed(kick_input) && reset_out_n |=> reset_out_n [*8])
        else $error("reset soon after kick edge");
    chk_second_gap: assert property (second_tick |=> !second_tick [*8])
        else $error("second ticks too close");
    chk_trec_min_len: assert property ($rose(reset_out_n) |-> $past(reset_out_n, 8) == 1'b0)
        else $error("reset pulse too short");
    cover property (reg_rd && reg_addr == 8'h0f);
    cover property ($fell(reset_out_n));
    cover property (second_tick);
endmodule
bind rcaws_top rcaws_chk rcaws_chk_i (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .kick_input(kick_input), .reg_rdata(reg_rdata),
    .second_tick(second_tick), .shared_interrupt_pin_o(shared_interrupt_pin_o), .reset_out_n(reset_out_n));
`default_nettype wire

// file: test/rcaws_host.sv
// host processor model: register strobes, pointer and kick pin
`timescale 1ns/100ps
`default_nettype none
module rcaws_host (
    input wire logic mclk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic [7:0] ptr_addr,
    output logic kick_input
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ptr_addr = 8'h00;
        kick_input = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(negedge mclk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge mclk);
            reg_wr = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~d;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        begin
            @(negedge mclk);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge mclk);
            d = reg_rdata;
            reg_rd = 1'b0;
            reg_addr = ~a;
        end
    endtask
    task automatic kick;
        begin
            @(negedge mclk);
            kick_input = ~kick_input;
        end
    endtask
    task automatic point(input logic [7:0] a);
        begin
            @(negedge mclk);
            ptr_addr = a;
        end
    endtask
endmodule
`default_nettype wire

// file: test/rcaws_top_tb.sv
// self-checking bench for the rtc support block
`timescale 1ns/100ps
`default_nettype none
module rcaws_top_tb;
    logic mclk, rst, osc_tick, oscillator_halt, recovery_select, battery_backup, battery_low_flag;
    logic reg_wr, reg_rd, kick_input, second_tick, pin_o, oe_n, reset_out_n, square_out;
    logic [7:0] reg_addr, reg_wdata, ptr_addr, reg_rdata;
    logic [4:0] time_month;
    logic [5:0] time_date, time_hour;
    logic [6:0] time_min, time_sec;
    int err_count, compares, n, k;
    wire logic pin_lvl = oe_n ? 1'b1 : pin_o;
    rcaws_top #(.TREC_LONG_CYC(24), .TREC_DEF_CYC(32), .TREC_SHORT_CYC(20)) rcaws_top_i (
        .mclk(mclk), .rst(rst), .osc_tick(osc_tick), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .ptr_addr(ptr_addr), .oscillator_halt(oscillator_halt),
        .recovery_select(recovery_select), .battery_backup(battery_backup), .battery_low_flag(battery_low_flag),
        .kick_input(kick_input), .time_month(time_month), .time_date(time_date), .time_hour(time_hour),
        .time_min(time_min), .time_sec(time_sec), .reg_rdata(reg_rdata), .second_tick(second_tick),
        .shared_interrupt_pin_o(pin_o), .shared_interrupt_pin_oe_n(oe_n), .reset_out_n(reset_out_n),
        .square_out(square_out));
    rcaws_host rcaws_host_i (.mclk(mclk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ptr_addr(ptr_addr), .kick_input(kick_input));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic sig(input int s);
        sig = s == 0 ? pin_lvl : s == 1 ? reset_out_n : s == 2 ? square_out : second_tick;
    endfunction
    task automatic report_and_stop;
        begin
            $display("errors %0d compares %0d", err_count, compares);
            if (err_count == 0 && compares > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task automatic rng(input string nm, input int lo, input int hi, input int v);
        begin
            compares++;
            if (v < lo || v > hi)
            begin
                $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, v);
                err_count++;
            end
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        begin
            rcaws_host_i.rd(a, d);
            compares++;
            if (d !== exp)
            begin
                $display("ERROR %s expected %h seen %h", nm, exp, d);
                err_count++;
            end
        end
    endtask
    task automatic wait_sig(input int s, input logic v, input int lim, output int c);
        begin
            c = 0;
            while (sig(s) !== v && c < lim)
            begin
                @(negedge mclk);
                c++;
            end
            compares++;
            if (sig(s) !== v)
            begin
                $display("ERROR signal %0d expected %b seen %b", s, v, sig(s));
                err_count++;
                report_and_stop();
            end
        end
    endtask
    task automatic half(input int s, output int c);
        begin
            repeat (2) @(negedge mclk);
            wait_sig(s, ~sig(s), 5000, c);
            wait_sig(s, ~sig(s), 5000, c);
        end
    endtask
    task automatic toggles(input int s, input int cyc, output int c);
        logic last;
        begin
            repeat (2) @(negedge mclk);
            c = 0;
            last = sig(s);
            repeat (cyc)
            begin
                @(negedge mclk);
                if (sig(s) !== last) c++;
                last = sig(s);
            end
        end
    endtask
    initial
    begin
        err_count = 0;
        compares = 0;
        rst = 1'b1;
        osc_tick = 1'b0;
        oscillator_halt = 1'b0;
        recovery_select = 1'b1;
        battery_backup = 1'b0;
        battery_low_flag = 1'b0;
        time_month = 5'h01;
        time_date = 6'h01;
        time_hour = 6'h00;
        time_min = 7'h00;
        time_sec = 7'h25;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        osc_tick = 1'b1;
        rdchk("ctrl", 8'h08, 8'h80);
        rdchk("wdog", 8'h09, 8'h00);
        rdchk("al_month", 8'h0a, 8'h00);
        rdchk("sqw", 8'h13, 8'h00);
        rdchk("flags", 8'h0f, 8'h00);
        rcaws_host_i.wr(8'h08, 8'h00);
        wait_sig(0, 1'b0, 4, n);
        rcaws_host_i.wr(8'h08, 8'h80);
        wait_sig(0, 1'b1, 4, n);
        rcaws_host_i.wr(8'h0a, 8'h40);
        for (k = 1; k < 7; k++)
        begin
            rcaws_host_i.wr(8'h13, {k[3:0], 4'h0});
            half(2, n);
            rng("sq_half", 1 << (k - 1), 1 << (k - 1), n);
        end
        rcaws_host_i.wr(8'h13, 8'h00);
        toggles(2, 100, n);
        rng("sq_off", 0, 0, n);
        rcaws_host_i.wr(8'h0a, 8'h00);
        rcaws_host_i.wr(8'h13, 8'h30);
        rdchk("sqw_kept", 8'h13, 8'h30);
        toggles(2, 100, n);
        rng("sq_disabled", 0, 0, n);
        rcaws_host_i.wr(8'h0a, 8'h40);
        rcaws_host_i.wr(8'h08, 8'hc0);
        rcaws_host_i.wr(8'h09, 8'h84);
        half(0, n);
        rng("ft_half", 32, 32, n);
        wait_sig(1, 1'b0, 4200, n);
        wait_sig(1, 1'b1, 40, n);
        rng("trec", 19, 21, n);
        rdchk("ctrl_clr", 8'h08, 8'h80);
        rdchk("wdog_clr", 8'h09, 8'h00);
        rdchk("al_month_clr", 8'h0a, 8'h00);
        rdchk("wdf_set", 8'h0f, 8'h80);
        rdchk("wdf_clr", 8'h0f, 8'h00);
        toggles(2, 50, n);
        rng("sq_after_wd", 0, 0, n);
        rcaws_host_i.wr(8'h09, 8'h08);
        rcaws_host_i.wr(8'h08, 8'hc0);
        repeat (3)
        begin
            toggles(0, 1500, n);
            rng("kicked_pin", 0, 0, n);
            rcaws_host_i.kick();
        end
        rcaws_host_i.wr(8'h09, 8'h08);
        wait_sig(0, 1'b0, 6200, n);
        rng("wd_time", 2048, 6144, n);
        rcaws_host_i.wr(8'h08, 8'hc0);
        toggles(0, 200, n);
        rng("wd_owns_pin", 0, 0, n);
        rdchk("wdf_irq", 8'h0f, 8'h80);
        rcaws_host_i.wr(8'h08, 8'h80);
        rcaws_host_i.wr(8'h09, 8'h00);
        wait_sig(0, 1'b1, 4, n);
        rcaws_host_i.wr(8'h0a, 8'h80);
        rcaws_host_i.wr(8'h0e, 8'h80);
        wait_sig(3, 1'b1, 33000, n);
        wait_sig(0, 1'b0, 4, n);
        rdchk("af_set", 8'h0f, 8'h40);
        rdchk("af_clr", 8'h0f, 8'h00);
        wait_sig(0, 1'b1, 4, n);
        rcaws_host_i.wr(8'h0b, 8'hc0);
        rcaws_host_i.wr(8'h0c, 8'h80);
        rcaws_host_i.wr(8'h0d, 8'h80);
        rcaws_host_i.point(8'h0f);
        wait_sig(3, 1'b1, 33000, n);
        toggles(0, 6, n);
        rng("held_off", 0, 0, n);
        rcaws_host_i.point(8'h00);
        wait_sig(0, 1'b0, 4, n);
        rdchk("af_late", 8'h0f, 8'h40);
        rst = 1'b1;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        battery_backup = 1'b1;
        rcaws_host_i.wr(8'h08, 8'ha1);
        rcaws_host_i.wr(8'h0a, 8'h80);
        rcaws_host_i.wr(8'h0e, 8'h80);
        wait_sig(3, 1'b1, 33000, n);
        rng("cal_second", 32500, 32512, n);
        toggles(0, 6, n);
        rng("backup_pin", 0, 0, n);
        rdchk("af_backup", 8'h0f, 8'h40);
        report_and_stop();
    end
endmodule
`default_nettype wire
